// ### hw/limiter_pkg.sv
package limiter_pkg;
    // Data path widths
    localparam int SAMPLE_W = 24;
    localparam int ADDR_W = 8;
    localparam int REG_W = 9;
    localparam int MANT_W = 16;
    localparam int ATTEN_W = 20;
    localparam int FRAC_W = 16;

    // Register indices and byte addresses
    localparam logic [ADDR_W-1:0] DAC_CONTROL_IDX = 8'h0a;
    localparam logic [ADDR_W-1:0] LIM_CTL_ONE_IDX = 8'h18;
    localparam logic [ADDR_W-1:0] LIM_CTL_TWO_IDX = 8'h19;
    localparam logic [ADDR_W-1:0] STATUS_IDX = 8'h1a;
    localparam logic [ADDR_W-1:0] DAC_CONTROL_ADDR = 8'(DAC_CONTROL_IDX * 4);
    localparam logic [ADDR_W-1:0] LIM_CTL_ONE_ADDR = 8'(LIM_CTL_ONE_IDX * 4);
    localparam logic [ADDR_W-1:0] LIM_CTL_TWO_ADDR = 8'(LIM_CTL_TWO_IDX * 4);
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'(STATUS_IDX * 4);

    // Reset values
    localparam logic [REG_W-1:0] DAC_CONTROL_RST = 9'h000;
    localparam logic [REG_W-1:0] LIM_CTL_ONE_RST = 9'h032;
    localparam logic [REG_W-1:0] LIM_CTL_TWO_RST = 9'h000;

    // Field positions
    localparam int ZERO_MUTE_EN_BIT = 2;
    localparam int LIM_EN_BIT = 8;
    localparam int ATK_LSB = 0;
    localparam int DCY_LSB = 4;
    localparam int BOOST_LSB = 0;
    localparam int LVL_LSB = 4;
    localparam int STAT_MUTE_BIT = 0;
    localparam int STAT_LIMIT_BIT = 1;
    localparam int STAT_ATTEN_LSB = 8;

    // Field limits
    localparam logic [3:0] RATE_CODE_MAX = 4'h0b;
    localparam logic [3:0] BOOST_CODE_MAX = 4'h0c;
    localparam logic [2:0] LVL_CODE_MAX = 3'h5;
    localparam logic [10:0] ZERO_RUN_LEN = 11'h400;

    // Rate times per 6 dB, referred to the 44.1 kHz sample rate
    localparam longint ATK_TIME_NS = 94000;
    localparam longint DCY_TIME_NS = 750000;
    localparam longint REF_RATE_HZ = 44100;
    localparam longint GAIN_UNIT = 65536;
    localparam logic [ATTEN_W-1:0] ATK_STEP0 =
        20'((GAIN_UNIT * 1_000_000_000) / (ATK_TIME_NS * REF_RATE_HZ));
    localparam logic [ATTEN_W-1:0] DCY_STEP0 =
        20'((GAIN_UNIT * 1_000_000_000) / (DCY_TIME_NS * REF_RATE_HZ));

    // Gain scaling: one gain unit is one 6 dB doubling
    localparam logic [15:0] BOOST_DB_STEP = 16'h2a85;
    localparam logic [ATTEN_W-1:0] ATTEN_MAX = 20'h8_0000;
    localparam logic signed [5:0] MANT_SHIFT = 6'sh0f;
    localparam logic [MANT_W-1:0] MANT_LUT [16] = '{
        16'h8000, 16'h85ab, 16'h8b96, 16'h91c4, 16'h9838, 16'h9ef5, 16'ha5ff, 16'had58,
        16'hb505, 16'hbd09, 16'hc567, 16'hce25, 16'hd745, 16'he0cd, 16'heac1, 16'hf525};

    // Magnitudes at -0.5 dB .. -6.5 dB of full scale, 1 dB apart
    localparam logic [SAMPLE_W-1:0] THRESH_LUT [7] = '{
        24'h78_d703, 24'h6b_b33e, 24'h5f_fc6c, 24'h55_8c2f,
        24'h4c_3ea5, 24'h43_f412, 24'h3c_9011};

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### hw/gain_if.sv
`timescale 1ns/1ps
`default_nettype none
interface gain_if #(parameter int W = 24);
    logic signed [W-1:0] sample;
    logic valid;
    logic [15:0] mant;
    logic signed [4:0] expo;
    logic signed [W-1:0] res;
    logic res_valid;

    modport src (output sample, valid, mant, expo, input res, res_valid);
    modport dst (input sample, valid, mant, expo, output res, res_valid);
endinterface
`default_nettype wire

// ### hw/gain_stage.sv
`timescale 1ns/1ps
`default_nettype none
module gain_stage #(
    parameter int W = 24
) (
    input wire logic aclk,
    input wire logic aresetn,
    gain_if.dst g
);
    localparam logic signed [W+16:0] POS_MAX = (W+17)'((64'sd1 <<< (W-1)) - 64'sd1);
    localparam logic signed [W+16:0] NEG_MAX = -POS_MAX - (W+17)'(1);

    logic signed [W+16:0] prod;
    logic signed [W+16:0] shifted;
    logic signed [5:0] sh_s;
    logic [4:0] sh;
    logic over_pos;
    logic over_neg;

    // Factor is mant * 2^expo / 2^15; shift range stays within 14..23
    assign prod = g.sample * $signed({1'b0, g.mant});
    assign sh_s = limiter_pkg::MANT_SHIFT - 6'(g.expo);
    assign sh = sh_s[4:0];
    assign shifted = prod >>> sh;
    assign over_pos = shifted > POS_MAX;
    assign over_neg = shifted < NEG_MAX;

    // Saturate rather than wrap; boost can push peaks past full scale
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            g.res <= '0;
            g.res_valid <= 1'b0;
        end else begin
            g.res_valid <= g.valid;
            if (g.valid) begin
                g.res <= over_pos ? POS_MAX[W-1:0] : over_neg ? NEG_MAX[W-1:0] : shifted[W-1:0];
            end
        end
    end
endmodule // gain_stage
`default_nettype wire

// ### hw/dac_automute_limiter.sv
`timescale 1ns/1ps
`default_nettype none
module dac_automute_limiter (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [limiter_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [limiter_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Sample stream
    input wire logic signed [limiter_pkg::SAMPLE_W-1:0] sample_in,
    input wire logic sample_in_valid,
    output logic signed [limiter_pkg::SAMPLE_W-1:0] sample_out,
    output logic sample_out_valid,
    output logic analog_mute
);
    localparam int W = limiter_pkg::SAMPLE_W;
    localparam int RW = limiter_pkg::REG_W;
    localparam int AW = limiter_pkg::ATTEN_W;

    gain_if #(.W(W)) gif ();

    // Register and state flops, plus the atten_d and zero_run_d next-state values
    logic [RW-1:0] dac_control_q;
    logic [RW-1:0] limiter_control_one_q;
    logic [RW-1:0] limiter_control_two_q;
    logic [AW-1:0] atten_q;
    logic [AW-1:0] atten_d;
    logic limiting_q;
    logic [10:0] zero_run_q;
    logic [10:0] zero_run_d;
    logic mute_q;

    // Bus flops
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic aw_have_q;
    logic w_have_q;
    logic [limiter_pkg::ADDR_W-1:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    // Field extraction
    logic zero_run_mute_en;
    logic limiter_en;
    logic [3:0] limiter_attack_sel;
    logic [3:0] limiter_decay_sel;
    logic [2:0] limiter_level_sel;
    logic [3:0] limiter_gain_lift;
    assign zero_run_mute_en = dac_control_q[limiter_pkg::ZERO_MUTE_EN_BIT];
    assign limiter_en = limiter_control_one_q[limiter_pkg::LIM_EN_BIT];
    assign limiter_attack_sel = limiter_control_one_q[limiter_pkg::ATK_LSB +: 4];
    assign limiter_decay_sel = limiter_control_one_q[limiter_pkg::DCY_LSB +: 4];
    assign limiter_level_sel = limiter_control_two_q[limiter_pkg::LVL_LSB +: 3];
    assign limiter_gain_lift = limiter_control_two_q[limiter_pkg::BOOST_LSB +: 4];

    // Rate codes past the table end all act as the slowest entry
    logic [3:0] atk_code;
    logic [3:0] dcy_code;
    logic [AW-1:0] atk_step;
    logic [AW-1:0] dcy_step;
    assign atk_code = (limiter_attack_sel > limiter_pkg::RATE_CODE_MAX) ?
        limiter_pkg::RATE_CODE_MAX : limiter_attack_sel;
    assign dcy_code = (limiter_decay_sel > limiter_pkg::RATE_CODE_MAX) ?
        limiter_pkg::RATE_CODE_MAX : limiter_decay_sel;
    assign atk_step = limiter_pkg::ATK_STEP0 >> atk_code;
    assign dcy_step = limiter_pkg::DCY_STEP0 >> dcy_code;

    // Thresholds half a dB either side of the programmed level
    logic [2:0] lvl_code;
    logic [W-1:0] upper_thr;
    logic [W-1:0] lower_thr;
    assign lvl_code = (limiter_level_sel > limiter_pkg::LVL_CODE_MAX) ?
        limiter_pkg::LVL_CODE_MAX : limiter_level_sel;
    assign upper_thr = limiter_pkg::THRESH_LUT[lvl_code];
    assign lower_thr = limiter_pkg::THRESH_LUT[3'(lvl_code + 3'h1)];

    // Net gain in 6 dB units: boost minus limiter attenuation
    logic [3:0] boost_code;
    logic [AW-1:0] boost_q16;
    logic signed [AW:0] gain_total;
    assign boost_code = (limiter_gain_lift > limiter_pkg::BOOST_CODE_MAX) ?
        limiter_pkg::BOOST_CODE_MAX : limiter_gain_lift;
    assign boost_q16 = AW'(boost_code * limiter_pkg::BOOST_DB_STEP);
    assign gain_total = $signed({1'b0, boost_q16}) - $signed({1'b0, atten_q});

    // Table entry plus a linear step toward the next one
    // The bare 16-entry table misses 1 dB steps by over a third of a dB
    localparam int MF_W = limiter_pkg::FRAC_W - 4;
    logic [3:0] mant_idx;
    logic [MF_W-1:0] mant_frac;
    logic [16:0] mant_lo;
    logic [16:0] mant_hi;
    logic [16+MF_W:0] mant_span;
    logic [16:0] mant_fine;
    assign mant_idx = gain_total[limiter_pkg::FRAC_W-1 -: 4];
    assign mant_frac = gain_total[MF_W-1:0];
    assign mant_lo = {1'b0, limiter_pkg::MANT_LUT[mant_idx]};
    assign mant_hi = (mant_idx == 4'hf) ? 17'h1_0000 :
        {1'b0, limiter_pkg::MANT_LUT[4'(mant_idx + 4'h1)]};
    assign mant_span = (mant_hi - mant_lo) * mant_frac;
    assign mant_fine = mant_lo + 17'(mant_span >> MF_W);

    // Feed the gain stage straight from the input strobe
    assign gif.sample = sample_in;
    assign gif.valid = sample_in_valid;
    assign gif.expo = gain_total[AW:limiter_pkg::FRAC_W];
    assign gif.mant = mant_fine[15:0];

    gain_stage #(.W(W)) u_gain (
        .aclk(aclk),
        .aresetn(aresetn),
        .g(gif)
    );

    // Level detection on the processed sample
    logic [W-1:0] out_mag;
    logic above_upper;
    logic below_lower;
    logic [AW:0] atten_sum;
    assign out_mag = gif.res[W-1] ? W'(-gif.res) : W'(gif.res);
    assign above_upper = out_mag > upper_thr;
    assign below_lower = out_mag < lower_thr;
    assign atten_sum = {1'b0, atten_q} + {1'b0, atk_step};

    // Attack while over, decay while under, hold inside the 1 dB band
    always_comb begin
        atten_d = atten_q;
        if (!limiter_en) begin
            atten_d = '0;
        end else if (gif.res_valid && above_upper) begin
            atten_d = (atten_sum > {1'b0, limiter_pkg::ATTEN_MAX}) ?
                limiter_pkg::ATTEN_MAX : atten_sum[AW-1:0];
        end else if (gif.res_valid && below_lower) begin
            atten_d = (atten_q > dcy_step) ? AW'(atten_q - dcy_step) : '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            atten_q <= '0;
            limiting_q <= 1'b0;
        end else begin
            atten_q <= atten_d;
            if (gif.res_valid) begin
                limiting_q <= limiter_en && above_upper;
            end
        end
    end

    // Zero-run counter; saturates so a long silence stays muted
    logic in_zero;
    assign in_zero = (sample_in == '0);
    always_comb begin
        zero_run_d = zero_run_q;
        if (sample_in_valid) begin
            if (!in_zero) begin
                zero_run_d = '0;
            end else if (zero_run_q != limiter_pkg::ZERO_RUN_LEN) begin
                zero_run_d = 11'(zero_run_q + 11'h001);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            zero_run_q <= '0;
            mute_q <= 1'b0;
        end else begin
            zero_run_q <= zero_run_d;
            // Non-zero sample clears the count, so mute drops the next edge
            mute_q <= zero_run_mute_en && (zero_run_d == limiter_pkg::ZERO_RUN_LEN);
        end
    end

    // Byte-lane merge of a write into a 9-bit register
    function automatic logic [RW-1:0] merge(input logic [RW-1:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
        logic [RW-1:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = data[7:0];
        end
        if (strb[1]) begin
            r[8] = data[8];
        end
        return r;
    endfunction

    // Write decode; status is read-only, so writes to it fail
    logic do_write;
    logic wr_dac;
    logic wr_one;
    logic wr_two;
    assign do_write = aw_have_q && w_have_q && !bvalid_q;
    assign wr_dac = do_write && (waddr_q == limiter_pkg::DAC_CONTROL_ADDR);
    assign wr_one = do_write && (waddr_q == limiter_pkg::LIM_CTL_ONE_ADDR);
    assign wr_two = do_write && (waddr_q == limiter_pkg::LIM_CTL_TWO_ADDR);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dac_control_q <= limiter_pkg::DAC_CONTROL_RST;
            limiter_control_one_q <= limiter_pkg::LIM_CTL_ONE_RST;
            limiter_control_two_q <= limiter_pkg::LIM_CTL_TWO_RST;
        end else begin
            if (wr_dac) begin
                dac_control_q <= merge(dac_control_q, wdata_q, wstrb_q);
            end
            if (wr_one) begin
                limiter_control_one_q <= merge(limiter_control_one_q, wdata_q, wstrb_q);
            end
            if (wr_two) begin
                limiter_control_two_q <= merge(limiter_control_two_q, wdata_q, wstrb_q);
            end
        end
    end

    // Write channels taken in either order, response once both are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= limiter_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                awready_q <= 1'b0;
                aw_have_q <= 1'b1;
                waddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q) begin
                wready_q <= 1'b0;
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q <= (wr_dac || wr_one || wr_two) ?
                    limiter_pkg::RESP_OKAY : limiter_pkg::RESP_SLVERR;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // Read decode; status word shows live block state
    logic [31:0] status_word;
    logic [31:0] rd_word;
    logic rd_hit;
    assign status_word = {16'h0000, atten_q[AW-1 -: 8], 6'h00, limiting_q, mute_q};
    assign rd_hit = (s_axi_araddr == limiter_pkg::DAC_CONTROL_ADDR) ||
                    (s_axi_araddr == limiter_pkg::LIM_CTL_ONE_ADDR) ||
                    (s_axi_araddr == limiter_pkg::LIM_CTL_TWO_ADDR) ||
                    (s_axi_araddr == limiter_pkg::STATUS_ADDR);
    assign rd_word =
        (s_axi_araddr == limiter_pkg::DAC_CONTROL_ADDR) ? {23'h00_0000, dac_control_q} :
        (s_axi_araddr == limiter_pkg::LIM_CTL_ONE_ADDR) ? {23'h00_0000, limiter_control_one_q} :
        (s_axi_araddr == limiter_pkg::LIM_CTL_TWO_ADDR) ? {23'h00_0000, limiter_control_two_q} :
        (s_axi_araddr == limiter_pkg::STATUS_ADDR) ? status_word : 32'h0000_0000;

    // One read in flight; arready drops while the data waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= limiter_pkg::RESP_OKAY;
        end else begin
            if (s_axi_arvalid && arready_q) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= rd_word;
                rresp_q <= rd_hit ? limiter_pkg::RESP_OKAY : limiter_pkg::RESP_SLVERR;
            end
            if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    // Outputs, all flop-driven
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign sample_out = gif.res;
    assign sample_out_valid = gif.res_valid;
    assign analog_mute = mute_q;
endmodule // dac_automute_limiter
`default_nettype wire

// ### sim/dac_automute_limiter_sva.sv
`timescale 1ns/1ps
`default_nettype none
module limiter_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic signed [limiter_pkg::SAMPLE_W-1:0] sample_in,
    input wire logic sample_in_valid,
    input wire logic signed [limiter_pkg::SAMPLE_W-1:0] sample_out,
    input wire logic sample_out_valid,
    input wire logic analog_mute
);
    logic [10:0] zrun_q;
    logic [10:0] zrun_d;
    logic zero_in;

    // Own zero-run count, runs whether or not the mute is enabled
    assign zero_in = sample_in_valid && (sample_in == '0);
    assign zrun_d = !sample_in_valid ? zrun_q : !zero_in ? 11'h000 :
        (zrun_q == 11'h400) ? zrun_q : zrun_q + 11'h001;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            zrun_q <= 11'h000;
        end else begin
            zrun_q <= zrun_d;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_MUTE_RUN: assert property (analog_mute |-> zrun_q == 11'h400)
        else $error("mute high without a full zero run");
    AST_UNMUTE: assert property (sample_in_valid && !zero_in |=> !analog_mute)
        else $error("mute not released by non-zero sample");
    AST_ZERO_OUT: assert property (zero_in |=> sample_out == '0)
        else $error("zero sample not passed as zero");
    AST_OUT_VALID: assert property (sample_in_valid |=> sample_out_valid)
        else $error("sample result missing");
    AST_NO_EXTRA: assert property (!sample_in_valid |=> !sample_out_valid)
        else $error("result without a sample");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_B_ANSWER: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
        else $error("write response late");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");

    COV_MUTE: cover property ($rose(analog_mute));
    COV_UNMUTE: cover property ($fell(analog_mute));
    COV_SAT: cover property (sample_out_valid && sample_out == 24'h7f_ffff);
    COV_ERR: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // limiter_checker

bind dac_automute_limiter limiter_checker u_chk (.aclk, .aresetn, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sample_in,
    .sample_in_valid, .sample_out, .sample_out_valid, .analog_mute);
`default_nettype wire

// ### sim/sample_source.sv
`timescale 1ns/1ps
`default_nettype none
module sample_source (
    input wire logic aclk,
    output logic signed [limiter_pkg::SAMPLE_W-1:0] sample_in,
    output logic sample_in_valid
);
    // Quiet line at time zero
    initial begin
        sample_in = '0;
        sample_in_valid = 1'b0;
    end

    // One sample per strobe; back to back calls keep the strobe up
    task automatic send(input logic signed [limiter_pkg::SAMPLE_W-1:0] v);
        sample_in <= v;
        sample_in_valid <= 1'b1;
        @(posedge aclk);
        #1;
    endtask

    // Between strobes the data line is inverted; a second call restores the stale sample
    task automatic idle(input int n);
        sample_in_valid <= 1'b0;
        sample_in <= ~sample_in;
        repeat (n) @(posedge aclk);
        #1;
    endtask
endmodule // sample_source
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int LIMIT = 50000;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [limiter_pkg::ADDR_W-1:0] s_axi_awaddr = '0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [limiter_pkg::ADDR_W-1:0] s_axi_araddr = '0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic signed [limiter_pkg::SAMPLE_W-1:0] sample_in;
    logic sample_in_valid;
    logic signed [limiter_pkg::SAMPLE_W-1:0] sample_out;
    logic sample_out_valid;
    logic analog_mute;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    int zrun = 0;
    logic mute_en = 1'b0;

    dac_automute_limiter dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_in, .sample_in_valid,
        .sample_out, .sample_out_valid, .analog_mute);
    sample_source src (.aclk, .sample_in, .sample_in_valid);

    always #10 aclk = ~aclk;

    // Hang guard
    always @(posedge aclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Rate step per sample in gain units, codes above 11 as 11
    function automatic int rate(input real t, input int c);
        return $rtoi(65536.0 / (t * 44100.0)) >> (c > 11 ? 11 : c);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        src.idle(1);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check(32'(s_axi_bresp), 32'(r));
    endtask

    task automatic cfg(input logic [7:0] a, input logic [31:0] d);
        wr(a, d, limiter_pkg::RESP_OKAY);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        src.idle(1);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, d);
        check(32'(s_axi_rresp), 32'(r));
    endtask

    // One sample through, mute model updated; tol below zero skips the value
    task automatic put(input int v, input int exp, input int tol);
        int diff;
        src.send(24'(v));
        zrun = (v != 0) ? 0 : (zrun < 1024 ? zrun + 1 : zrun);
        check(analog_mute, mute_en && zrun >= 1024);
        check(sample_out_valid, 1'b1);
        if (tol >= 0) begin
            diff = int'(sample_out) - exp;
            check(diff <= tol && diff >= -tol, 1'b1);
        end
        // Gap so this result's gain update reaches the next sample
        src.idle(1);
    endtask

    initial begin
        int n;
        int atn;
        int v;
        real up;
        logic [31:0] d;
        logic [7:0] regs [3];
        regs = '{limiter_pkg::DAC_CONTROL_ADDR, limiter_pkg::LIM_CTL_ONE_ADDR,
            limiter_pkg::LIM_CTL_TWO_ADDR};
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        v = $urandom(32'h23b3_1cf4);
        rd_chk(regs[0], 32'h0000_0000, 2'h0);
        rd_chk(regs[1], 32'h0000_0032, 2'h0);
        rd_chk(regs[2], 32'h0000_0000, 2'h0);
        rd_chk(8'h10, 32'h0000_0000, limiter_pkg::RESP_SLVERR);
        wr(8'h10, 32'h0000_01ff, limiter_pkg::RESP_SLVERR);
        wr(limiter_pkg::STATUS_ADDR, 32'h0000_01ff, limiter_pkg::RESP_SLVERR);
        // Random words keep only their low nine bits
        for (int i = 0; i < 3; i++) begin
            d = $urandom;
            cfg(regs[i], d);
            rd_chk(regs[i], d & 32'h0000_01ff, 2'h0);
        end
        cfg(regs[0], 32'h0000_0000);
        cfg(regs[2], 32'h0000_0000);
        cfg(regs[1], 32'h0000_0100);
        // Below the upper threshold with no lift, samples pass untouched
        repeat (100) begin
            v = int'($urandom_range(32'h00e0_0000)) - 32'h0070_0000;
            put(v, v, 0);
        end
        // Attack then decay over rate codes 1 to 15
        for (int c = 1; c < 16; c++) begin
            cfg(regs[2], 32'h0000_0050);
            cfg(regs[1], 32'(c * 17));
            put(0, 0, 0);
            cfg(regs[1], 32'(256 + c * 17));
            n = 4 << ((c > 9 ? 9 : c) - 1);
            repeat (n) put(32'h007f_ffff, 0, -1);
            atn = rate(94.0e-6, c) * n;
            rd_chk(limiter_pkg::STATUS_ADDR, 32'((atn >> 12) << 8) | 32'h2, 2'h0);
            repeat (n / 2) put(0, 0, 0);
            atn = atn - rate(750.0e-6, c) * (n / 2);
            rd_chk(limiter_pkg::STATUS_ADDR, 32'((atn >> 12) << 8), 2'h0);
        end
        // Settled peak sits between 0.83 times the upper threshold and the threshold for each level code
        for (int l = 0; l < 8; l++) begin
            cfg(regs[2], 32'(l * 16));
            cfg(regs[1], 32'h0000_00a0);
            put(0, 0, 0);
            cfg(regs[1], 32'h0000_01a0);
            repeat (16) put(32'h007f_ffff, 0, -1);
            up = 8388608.0 * 10.0 ** (-((l > 5 ? 5 : l) + 0.5) / 20.0);
            check(sample_out <= up && sample_out >= up * 0.83, 1'b1);
        end
        // Lift codes with the limiter off, then on
        for (int k = 0; k < 32; k++) begin
            cfg(regs[1], 32'((k / 16) * 256));
            cfg(regs[2], 32'(k % 16));
            up = 65536.0 * 10.0 ** ((k % 16 > 12 ? 12 : k % 16) / 20.0);
            repeat (59) put(32'h0001_0000, 0, -1);
            put(32'h0001_0000, $rtoi(up), $rtoi(up) / 128 + 2);
        end
        cfg(regs[1], 32'h0000_0000);
        put(32'h007f_ffff, 32'h007f_ffff, 0);
        put(-32'h0080_0000, -32'h0080_0000, 0);
        // Zero runs: exact count, saturation, release, re-enable
        cfg(regs[2], 32'h0000_0000);
        cfg(regs[0], 32'h0000_0004);
        mute_en = 1'b1;
        repeat (1030) put(0, 0, 0);
        put(5, 5, 0);
        repeat (1023) put(0, 0, 0);
        put(1, 1, 0);
        cfg(regs[0], 32'h0000_0000);
        mute_en = 1'b0;
        repeat (1100) put(0, 0, 0);
        cfg(regs[0], 32'h0000_0004);
        mute_en = 1'b1;
        @(posedge aclk);
        #1;
        check(analog_mute, 1'b1);
        put(7, 7, 0);
        src.idle(1);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
